// ### core/ptrf_bank.sv
// Storage for two sets of sixteen double-word pointer registers.
// Assumes the control logic never writes the same register on both ports at once.
`default_nettype none
module ptrf_bank
    import ptrf_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_b,
    ptrf_bank_if.bank   bus
);
    typedef struct packed {
        logic [1:0][PTRF_NUM_REGS-1:0][PTRF_DATA_W-1:0] regs;
    } ptrf_bank_state_type;

    ptrf_bank_state_type state_ff;
    ptrf_bank_state_type nxt_state;

    // Two asynchronous reads of the selected set
    assign bus.rd_a_data = state_ff.regs[bus.bank_sel][bus.rd_a_idx];
    assign bus.rd_b_data = state_ff.regs[bus.bank_sel][bus.rd_b_idx];

    // Two write ports, port B applied last
    always_comb begin
        nxt_state = state_ff;
        if (bus.wr_a_en) begin
            nxt_state.regs[bus.bank_sel][bus.wr_a_idx] = bus.wr_a_data;
        end
        if (bus.wr_b_en) begin
            nxt_state.regs[bus.bank_sel][bus.wr_b_idx] = bus.wr_b_data;
        end
    end

    // Register the bank
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule : ptrf_bank
`default_nettype wire

// ### core/ptrf_bank_if.sv
// Interface between the pointer register control logic and its storage bank.
// Assumes both ends run on the same clock.
`default_nettype none
interface ptrf_bank_if;
    import ptrf_pkg::*;
    logic                    bank_sel;
    logic [PTRF_IDX_W-1:0]   rd_a_idx;
    logic [PTRF_IDX_W-1:0]   rd_b_idx;
    logic [PTRF_DATA_W-1:0]  rd_a_data;
    logic [PTRF_DATA_W-1:0]  rd_b_data;
    logic                    wr_a_en;
    logic [PTRF_IDX_W-1:0]   wr_a_idx;
    logic [PTRF_DATA_W-1:0]  wr_a_data;
    logic                    wr_b_en;
    logic [PTRF_IDX_W-1:0]   wr_b_idx;
    logic [PTRF_DATA_W-1:0]  wr_b_data;
    modport ctrl (output bank_sel, rd_a_idx, rd_b_idx, wr_a_en, wr_a_idx, wr_a_data,
                  wr_b_en, wr_b_idx, wr_b_data, input rd_a_data, rd_b_data);
    modport bank (input bank_sel, rd_a_idx, rd_b_idx, wr_a_en, wr_a_idx, wr_a_data,
                  wr_b_en, wr_b_idx, wr_b_data, output rd_a_data, rd_b_data);
endinterface : ptrf_bank_if
`default_nettype wire

// ### core/ptrf_pkg.sv
// Package for the pointer register file: widths, operation codes, conversion constants.
// Assumes a single 100 MHz clock domain shared by the execution unit.
`default_nettype none
package ptrf_pkg;
    localparam int            PTRF_NUM_REGS       = 16;
    localparam int            PTRF_IDX_W          = 4;
    localparam int            PTRF_WORD_W         = 16;
    localparam int            PTRF_DATA_W         = 32;
    localparam logic [31:0]   PTRF_RESET_VALUE    = 32'h0000_0000;
    localparam logic [31:0]   PTRF_TIMER_PV_BASE  = 32'h0000_0000;
    localparam logic [31:0]   PTRF_LEGACY_DELTA   = 32'h0000_0000;
    localparam logic [31:0]   PTRF_STEP_ONE       = 32'h0000_0001;
    localparam logic [31:0]   PTRF_STEP_TWO       = 32'h0000_0002;
    localparam int            PTRF_SHARED_DEFAULT = 0;

    // Operations offered to the execution unit
    typedef enum logic [3:0] {
        PTRF_OP_NONE,
        PTRF_OP_LOAD_LOCATION,
        PTRF_OP_LOAD_TIMER_LOCATION,
        PTRF_OP_INDIRECT,
        PTRF_OP_READ,
        PTRF_OP_DOUBLE_MOVE,
        PTRF_OP_DOUBLE_EXCHANGE,
        PTRF_OP_DOUBLE_COMPARE,
        PTRF_OP_INCREMENT,
        PTRF_OP_DECREMENT,
        PTRF_OP_ADD,
        PTRF_OP_SUBTRACT,
        PTRF_OP_CONVERT_FROM_LEGACY,
        PTRF_OP_CONVERT_TO_LEGACY
    } ptrf_op_type;

    // Indirect operand address modes
    typedef enum logic [2:0] {
        PTRF_MODE_PLAIN,
        PTRF_MODE_CONST,
        PTRF_MODE_DATA_OFFSET,
        PTRF_MODE_POST_INC1,
        PTRF_MODE_POST_INC2,
        PTRF_MODE_PRE_DEC1,
        PTRF_MODE_PRE_DEC2
    } ptrf_mode_type;
endpackage : ptrf_pkg
`default_nettype wire

// ### core/ptrf_top.sv
// Pointer register file with operand address generation for the execution unit.
// Assumes one request per cycle with all request fields valid while req_valid is high.
//
// Overview of operation
// - Sixteen pointer registers, each one 32-bit double word.
// - A register holds any absolute bit or word address, timer values included.
// - Load operations write a location's address; one variant offsets to timer values.
// - Indirect access yields the address held in the register as effective address.
// - A signed constant adds to the register contents for the effective address.
// - An offset data register's contents add to the register for the address.
// - Auto-increment modes raise the register by one or two.
// - Auto-decrement modes lower the register by one or two.
// - Only the restricted direct operations read or write a register as data.
// - Read operation returns the held address to the destination operand.
// - Double move, exchange and compare act on whole two-word values.
// - Double increment, decrement, signed add and subtract modify the register.
// - Conversion translates addresses to and from the legacy address format.
// - Per-task or shared sets; status reads 0 separate, 1 shared.
`default_nettype none
module ptrf_top
    import ptrf_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    req_valid,
    input  wire ptrf_op_type             req_op,
    input  wire ptrf_mode_type           req_mode,
    input  wire logic [PTRF_IDX_W-1:0]   req_dst_idx,
    input  wire logic [PTRF_IDX_W-1:0]   req_src_idx,
    input  wire logic [PTRF_DATA_W-1:0]  req_operand,
    input  wire logic                    cfg_shared_sets,
    input  wire logic                    task_sel,
    output logic                         rsp_valid,
    output logic [PTRF_DATA_W-1:0]       rsp_data,
    output logic [PTRF_DATA_W-1:0]       rsp_eff_addr,
    output logic                         rsp_equal,
    output logic                         rsp_less,
    output logic                         rsp_greater,
    output logic                         shared_sets_status
);
    typedef struct packed {
        logic                    rsp_valid;
        logic [PTRF_DATA_W-1:0]  rsp_data;
        logic [PTRF_DATA_W-1:0]  rsp_eff_addr;
        logic                    rsp_equal;
        logic                    rsp_less;
        logic                    rsp_greater;
        logic                    shared;
    } ptrf_state_type;

    ptrf_state_type state_ff;
    ptrf_state_type nxt_state;

    ptrf_bank_if bank_bus ();

    ptrf_bank i_ptrf_bank (
        .clk   (clk),
        .rst_b (rst_b),
        .bus   (bank_bus.bank)
    );

    // Signed wrap-around add used by several operations
    function automatic logic [PTRF_DATA_W-1:0] ptrf_add(
        input logic [PTRF_DATA_W-1:0] a,
        input logic [PTRF_DATA_W-1:0] b
    );
        ptrf_add = a + b;
    endfunction : ptrf_add

    // Set selection: shared setting forces set 0
    assign bank_bus.bank_sel = cfg_shared_sets ? 1'b0 : task_sel;
    assign bank_bus.rd_a_idx = req_dst_idx;
    assign bank_bus.rd_b_idx = req_src_idx;

    logic [PTRF_DATA_W-1:0] cur_a;
    logic [PTRF_DATA_W-1:0] cur_b;
    assign cur_a = bank_bus.rd_a_data;
    assign cur_b = bank_bus.rd_b_data;

    // Operation decode and next state
    always_comb begin
        nxt_state                = state_ff;
        nxt_state.rsp_valid      = 1'b0;
        nxt_state.shared         = cfg_shared_sets;
        bank_bus.wr_a_en         = 1'b0;
        bank_bus.wr_a_idx        = req_dst_idx;
        bank_bus.wr_a_data       = cur_a;
        bank_bus.wr_b_en         = 1'b0;
        bank_bus.wr_b_idx        = req_src_idx;
        bank_bus.wr_b_data       = cur_b;
        if (req_valid) begin
            nxt_state.rsp_valid = 1'b1;
            // Only the direct operations below touch a register as data
            case (req_op)
                PTRF_OP_LOAD_LOCATION: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = req_operand;
                    nxt_state.rsp_data = req_operand;
                end
                PTRF_OP_LOAD_TIMER_LOCATION: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = ptrf_add(PTRF_TIMER_PV_BASE, req_operand);
                    nxt_state.rsp_data = bank_bus.wr_a_data;
                end
                PTRF_OP_INDIRECT: begin
                    nxt_state.rsp_eff_addr = cur_a;
                    case (req_mode)
                        PTRF_MODE_CONST: begin
                            nxt_state.rsp_eff_addr = ptrf_add(cur_a, req_operand);
                        end
                        PTRF_MODE_DATA_OFFSET: begin
                            nxt_state.rsp_eff_addr = ptrf_add(cur_a, req_operand);
                        end
                        PTRF_MODE_POST_INC1: begin
                            bank_bus.wr_a_en   = 1'b1;
                            bank_bus.wr_a_data = ptrf_add(cur_a, PTRF_STEP_ONE);
                        end
                        PTRF_MODE_POST_INC2: begin
                            bank_bus.wr_a_en   = 1'b1;
                            bank_bus.wr_a_data = ptrf_add(cur_a, PTRF_STEP_TWO);
                        end
                        PTRF_MODE_PRE_DEC1: begin
                            bank_bus.wr_a_en   = 1'b1;
                            bank_bus.wr_a_data = cur_a - PTRF_STEP_ONE;
                        end
                        PTRF_MODE_PRE_DEC2: begin
                            bank_bus.wr_a_en   = 1'b1;
                            bank_bus.wr_a_data = cur_a - PTRF_STEP_TWO;
                        end
                        default: begin
                            nxt_state.rsp_eff_addr = cur_a;
                        end
                    endcase
                    nxt_state.rsp_data = cur_a;
                end
                PTRF_OP_READ: begin
                    nxt_state.rsp_data = cur_a;
                end
                PTRF_OP_DOUBLE_MOVE: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = cur_b;
                    nxt_state.rsp_data = cur_b;
                end
                PTRF_OP_DOUBLE_EXCHANGE: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = cur_b;
                    bank_bus.wr_b_en   = (req_src_idx != req_dst_idx);
                    bank_bus.wr_b_data = cur_a;
                    nxt_state.rsp_data = cur_b;
                end
                PTRF_OP_DOUBLE_COMPARE: begin
                    nxt_state.rsp_equal   = (cur_a == cur_b);
                    nxt_state.rsp_less    = (cur_a < cur_b);
                    nxt_state.rsp_greater = (cur_a > cur_b);
                    nxt_state.rsp_data    = cur_a;
                end
                PTRF_OP_INCREMENT: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = ptrf_add(cur_a, PTRF_STEP_ONE);
                    nxt_state.rsp_data = bank_bus.wr_a_data;
                end
                PTRF_OP_DECREMENT: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = cur_a - PTRF_STEP_ONE;
                    nxt_state.rsp_data = bank_bus.wr_a_data;
                end
                PTRF_OP_ADD: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = ptrf_add(cur_a, req_operand);
                    nxt_state.rsp_data = bank_bus.wr_a_data;
                end
                PTRF_OP_SUBTRACT: begin
                    bank_bus.wr_a_en   = 1'b1;
                    bank_bus.wr_a_data = cur_a - req_operand;
                    nxt_state.rsp_data = bank_bus.wr_a_data;
                end
                PTRF_OP_CONVERT_FROM_LEGACY: begin
                    nxt_state.rsp_data = ptrf_add(req_operand, PTRF_LEGACY_DELTA);
                end
                PTRF_OP_CONVERT_TO_LEGACY: begin
                    nxt_state.rsp_data = req_operand - PTRF_LEGACY_DELTA;
                end
                default: begin
                    nxt_state.rsp_valid = 1'b1;
                end
            endcase
        end
    end

    // Register the response state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rsp_valid          = state_ff.rsp_valid;
    assign rsp_data           = state_ff.rsp_data;
    assign rsp_eff_addr       = state_ff.rsp_eff_addr;
    assign rsp_equal          = state_ff.rsp_equal;
    assign rsp_less           = state_ff.rsp_less;
    assign rsp_greater        = state_ff.rsp_greater;
    assign shared_sets_status = state_ff.shared;

    // Checks on the response path
    AST_RSP_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid |=> rsp_valid) else $error("missing response");
    AST_IDLE_NO_RSP: assert property (@(posedge clk) disable iff (!rst_b)
        !req_valid |=> !rsp_valid) else $error("spurious response");
    AST_EFF_PLAIN: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT && req_mode == PTRF_MODE_PLAIN
        |=> rsp_eff_addr == $past(cur_a)) else $error("plain address wrong");
    AST_EFF_CONST: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT && req_mode == PTRF_MODE_CONST
        |=> rsp_eff_addr == $past(cur_a) + $past(req_operand))
        else $error("constant offset wrong");
    AST_EFF_DR: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT && req_mode == PTRF_MODE_DATA_OFFSET
        |=> rsp_eff_addr == $past(cur_a) + $past(req_operand))
        else $error("data offset wrong");
    AST_INC2: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT && req_mode == PTRF_MODE_POST_INC2
        |-> bank_bus.wr_a_en && bank_bus.wr_a_data == cur_a + PTRF_STEP_TWO)
        else $error("increment by two wrong");
    AST_DEC1: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT && req_mode == PTRF_MODE_PRE_DEC1
        |-> bank_bus.wr_a_en && bank_bus.wr_a_data == cur_a - PTRF_STEP_ONE)
        else $error("decrement wrong");
    AST_POST_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT && req_mode == PTRF_MODE_POST_INC1
        |=> rsp_eff_addr == $past(cur_a)) else $error("address after adjust");
    AST_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_LOAD_LOCATION ##1
        req_valid && req_op == PTRF_OP_READ && $past(req_dst_idx) == req_dst_idx
        && $past(bank_bus.bank_sel) == bank_bus.bank_sel
        |=> rsp_data == $past(req_operand, 2)) else $error("load lost");
    AST_CMP: assert property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_DOUBLE_COMPARE
        |=> rsp_equal == ($past(cur_a) == $past(cur_b))) else $error("compare wrong");
    // Status copy is only owed once the flop has left reset
    AST_SHARED: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> shared_sets_status == $past(cfg_shared_sets))
        else $error("status wrong");

    COV_INDIRECT: cover property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_INDIRECT);
    COV_EXCHANGE: cover property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_DOUBLE_EXCHANGE);
    COV_LOAD_READ: cover property (@(posedge clk) disable iff (!rst_b)
        req_valid && req_op == PTRF_OP_LOAD_LOCATION ##1 req_valid && req_op == PTRF_OP_READ);
endmodule : ptrf_top
`default_nettype wire

// ### tb/ptrf_exec_model.sv
// Execution-unit model: presents requests and set selection to the register file.
// Assumes its tasks are entered just after a rising edge of clk.
`default_nettype none
module ptrf_exec_model
    import ptrf_pkg::*;
(
    input  wire logic                clk,
    output logic                     req_valid,
    output ptrf_op_type              req_op,
    output ptrf_mode_type            req_mode,
    output logic [PTRF_IDX_W-1:0]    req_dst_idx,
    output logic [PTRF_IDX_W-1:0]    req_src_idx,
    output logic [PTRF_DATA_W-1:0]   req_operand,
    output logic                     cfg_shared_sets,
    output logic                     task_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle values at time zero
    initial begin
        req_valid       = 1'b0;
        req_op          = PTRF_OP_NONE;
        req_mode        = PTRF_MODE_PLAIN;
        req_dst_idx     = 4'h0;
        req_src_idx     = 4'h0;
        req_operand     = 32'h0;
        cfg_shared_sets = 1'b0;
        task_sel        = 1'b0;
    end
    // Present one request now; returns at the edge that takes it
    task send(input ptrf_op_type op, input ptrf_mode_type md, input logic [3:0] dst,
              input logic [3:0] src, input logic [31:0] opnd);
        req_valid   <= 1'b1;
        req_op      <= op;
        req_mode    <= md;
        req_dst_idx <= dst;
        req_src_idx <= src;
        req_operand <= opnd;
        @(posedge clk);
    endtask : send
    // Drop the request; operand no longer shows the old value
    task release_req;
        req_valid   <= 1'b0;
        req_operand <= ~req_operand;
        #1;
    endtask : release_req
    // Change set selection at the next edge
    task set_cfg(input logic shared, input logic sel);
        @(posedge clk);
        cfg_shared_sets <= shared;
        task_sel        <= sel;
    endtask : set_cfg
endmodule : ptrf_exec_model
`default_nettype wire

// ### tb/ptrf_test.sv
// Self-checking bench for the pointer register file.
// Assumes the package constants and the one-cycle response of the design.
`default_nettype none
module ptrf_test
    import ptrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk;
    logic                    rst_b;
    logic                    req_valid;
    ptrf_op_type             req_op;
    ptrf_mode_type           req_mode;
    logic [PTRF_IDX_W-1:0]   req_dst_idx;
    logic [PTRF_IDX_W-1:0]   req_src_idx;
    logic [PTRF_DATA_W-1:0]  req_operand;
    logic                    cfg_shared_sets;
    logic                    task_sel;
    logic                    rsp_valid;
    logic [PTRF_DATA_W-1:0]  rsp_data;
    logic [PTRF_DATA_W-1:0]  rsp_eff_addr;
    logic                    rsp_equal;
    logic                    rsp_less;
    logic                    rsp_greater;
    logic                    shared_sets_status;
    int                      fails;
    int                      tests_run;
    ptrf_top i_ptrf_top (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
        .req_mode(req_mode), .req_dst_idx(req_dst_idx), .req_src_idx(req_src_idx),
        .req_operand(req_operand), .cfg_shared_sets(cfg_shared_sets), .task_sel(task_sel),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_eff_addr(rsp_eff_addr),
        .rsp_equal(rsp_equal), .rsp_less(rsp_less), .rsp_greater(rsp_greater),
        .shared_sets_status(shared_sets_status));
    ptrf_exec_model i_ptrf_exec_model (.clk(clk), .req_valid(req_valid), .req_op(req_op),
        .req_mode(req_mode), .req_dst_idx(req_dst_idx), .req_src_idx(req_src_idx),
        .req_operand(req_operand), .cfg_shared_sets(cfg_shared_sets), .task_sel(task_sel));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One isolated request and its response
    task op_do(input ptrf_op_type op, input ptrf_mode_type md, input logic [3:0] dst,
               input logic [3:0] src, input logic [31:0] opnd);
        @(posedge clk);
        i_ptrf_exec_model.send(op, md, dst, src, opnd);
        i_ptrf_exec_model.release_req;
        chk({31'h0, rsp_valid}, 32'h1);
    endtask : op_do
    // Flags packed as equal, less, greater
    function automatic logic [31:0] flags();
        return {29'h0, rsp_equal, rsp_less, rsp_greater};
    endfunction : flags
    // All sixteen registers of set 0 clear after reset
    task t_reset;
        chk(rsp_data, 32'h0);
        for (int r = 0; r < 16; r++) begin
            op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, r[3:0], 4'h0, 32'h0);
            chk(rsp_data, PTRF_RESET_VALUE);
        end
        chk({31'h0, shared_sets_status}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    // Loads of full-width addresses and read back
    task t_load;
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'hF, 4'h0, 32'hFFFF_FFFF);
        chk(rsp_data, 32'hFFFF_FFFF);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'hF, 4'h0, 32'h0);
        chk(rsp_data, 32'hFFFF_FFFF);
        op_do(PTRF_OP_LOAD_TIMER_LOCATION, PTRF_MODE_PLAIN, 4'h0, 4'h0, 32'h0000_0123);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h0, 4'h0, 32'h0);
        chk(rsp_data, PTRF_TIMER_PV_BASE + 32'h0000_0123);
        $display("test load done");
    endtask : t_load
    // Every indirect mode from a fresh base
    task t_indirect;
        ptrf_mode_type md;
        logic [31:0]   opnd;
        logic [31:0]   eff;
        logic [31:0]   nxt;
        for (int m = 0; m < 7; m++) begin
            md = ptrf_mode_type'(m);
            opnd = (md == PTRF_MODE_DATA_OFFSET) ? 32'h0000_0010 : 32'hFFFF_FFFE;
            eff = 32'h0000_1000;
            nxt = 32'h0000_1000;
            case (md)
                PTRF_MODE_CONST:       eff = 32'h0000_0FFE;
                PTRF_MODE_DATA_OFFSET: eff = 32'h0000_1010;
                PTRF_MODE_POST_INC1:   nxt = 32'h0000_1001;
                PTRF_MODE_POST_INC2:   nxt = 32'h0000_1002;
                PTRF_MODE_PRE_DEC1:    nxt = 32'h0000_0FFF;
                PTRF_MODE_PRE_DEC2:    nxt = 32'h0000_0FFE;
                default:               nxt = 32'h0000_1000;
            endcase
            op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h5, 4'h0, 32'h0000_1000);
            op_do(PTRF_OP_INDIRECT, md, 4'h5, 4'h0, opnd);
            chk(rsp_eff_addr, eff);
            chk(rsp_data, 32'h0000_1000);
            op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h5, 4'h0, 32'h0);
            chk(rsp_data, nxt);
        end
        $display("test indirect done");
    endtask : t_indirect
    // Load, post-increment, load and read in consecutive cycles
    task t_b2b;
        @(posedge clk);
        i_ptrf_exec_model.send(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h3, 4'h0, 32'h3000);
        i_ptrf_exec_model.send(PTRF_OP_INDIRECT, PTRF_MODE_POST_INC1, 4'h3, 4'h0, 32'h0);
        i_ptrf_exec_model.send(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h9, 4'h0, 32'h9000);
        i_ptrf_exec_model.send(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h9, 4'h0, 32'h0);
        i_ptrf_exec_model.release_req;
        chk({31'h0, rsp_valid}, 32'h1);
        chk(rsp_eff_addr, 32'h0000_3000);
        chk(rsp_data, 32'h0000_9000);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h3, 4'h0, 32'h0);
        chk(rsp_data, 32'h0000_3001);
        $display("test back to back done");
    endtask : t_b2b
    // Double move, exchange and unsigned compare
    task t_double;
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h1, 4'h0, 32'h8000_0000);
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h2, 4'h0, 32'h0000_0001);
        op_do(PTRF_OP_DOUBLE_MOVE, PTRF_MODE_PLAIN, 4'h6, 4'h1, 32'h0);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h6, 4'h0, 32'h0);
        chk(rsp_data, 32'h8000_0000);
        op_do(PTRF_OP_DOUBLE_COMPARE, PTRF_MODE_PLAIN, 4'h1, 4'h2, 32'h0);
        chk(flags(), 32'h1);
        op_do(PTRF_OP_DOUBLE_EXCHANGE, PTRF_MODE_PLAIN, 4'h1, 4'h2, 32'h0);
        chk(rsp_data, 32'h0000_0001);
        op_do(PTRF_OP_DOUBLE_COMPARE, PTRF_MODE_PLAIN, 4'h1, 4'h2, 32'h0);
        chk(flags(), 32'h2);
        op_do(PTRF_OP_DOUBLE_COMPARE, PTRF_MODE_PLAIN, 4'h2, 4'h6, 32'h0);
        chk(flags(), 32'h4);
        $display("test double done");
    endtask : t_double
    // Arithmetic wraps without carry
    task t_arith;
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h7, 4'h0, 32'hFFFF_FFFF);
        op_do(PTRF_OP_INCREMENT, PTRF_MODE_PLAIN, 4'h7, 4'h0, 32'h0);
        chk(rsp_data, 32'h0);
        op_do(PTRF_OP_DECREMENT, PTRF_MODE_PLAIN, 4'h7, 4'h0, 32'h0);
        chk(rsp_data, 32'hFFFF_FFFF);
        op_do(PTRF_OP_ADD, PTRF_MODE_PLAIN, 4'h7, 4'h0, 32'hFFFF_FFF0);
        chk(rsp_data, 32'hFFFF_FFEF);
        op_do(PTRF_OP_SUBTRACT, PTRF_MODE_PLAIN, 4'h7, 4'h0, 32'hFFFF_FFF0);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h7, 4'h0, 32'h0);
        chk(rsp_data, 32'hFFFF_FFFF);
        $display("test arith done");
    endtask : t_arith
    // Conversion leaves the register alone
    task t_convert;
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h8, 4'h0, 32'h0000_2000);
        op_do(PTRF_OP_CONVERT_FROM_LEGACY, PTRF_MODE_PLAIN, 4'h8, 4'h0, 32'h0000_0100);
        chk(rsp_data, 32'h0000_0100 + PTRF_LEGACY_DELTA);
        op_do(PTRF_OP_CONVERT_TO_LEGACY, PTRF_MODE_PLAIN, 4'h8, 4'h0, 32'h0000_0100);
        chk(rsp_data, 32'h0000_0100 - PTRF_LEGACY_DELTA);
        op_do(PTRF_OP_NONE, PTRF_MODE_PLAIN, 4'h8, 4'h0, 32'h0000_5555);
        chk(rsp_data, 32'h0000_0100 - PTRF_LEGACY_DELTA);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h8, 4'h0, 32'h0);
        chk(rsp_data, 32'h0000_2000);
        $display("test convert done");
    endtask : t_convert
    // Separate and shared register sets
    task t_sets;
        i_ptrf_exec_model.set_cfg(1'b0, 1'b1);
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h4, 4'h0, 32'h0000_ABCD);
        i_ptrf_exec_model.set_cfg(1'b0, 1'b0);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h4, 4'h0, 32'h0);
        chk(rsp_data, 32'h0);
        i_ptrf_exec_model.set_cfg(1'b1, 1'b1);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h4, 4'h0, 32'h0);
        chk(rsp_data, 32'h0);
        chk({31'h0, shared_sets_status}, 32'h1);
        i_ptrf_exec_model.set_cfg(1'b0, 1'b1);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h4, 4'h0, 32'h0);
        chk(rsp_data, 32'h0000_ABCD);
        $display("test sets done");
    endtask : t_sets
    // Reset in mid-run clears a loaded register
    task t_midreset;
        op_do(PTRF_OP_LOAD_LOCATION, PTRF_MODE_PLAIN, 4'h4, 4'h0, 32'h0000_4444);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(rsp_data, 32'h0);
        op_do(PTRF_OP_READ, PTRF_MODE_PLAIN, 4'h4, 4'h0, 32'h0);
        chk(rsp_data, PTRF_RESET_VALUE);
        $display("test mid-run reset done");
    endtask : t_midreset
    // Verdict and end of run
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        fails = 0;
        tests_run = 0;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        t_reset;
        t_load;
        t_indirect;
        t_b2b;
        t_double;
        t_arith;
        t_convert;
        t_sets;
        t_midreset;
        end_sim;
    end
endmodule : ptrf_test
`default_nettype wire
